// ---- src/frr_defines.svh ----
`ifndef FRR_DEFINES_SVH
`define FRR_DEFINES_SVH

// register indices; byte address is four times the index
`define FRR_IDX_FAULT_LOG 8'h00
`define FRR_IDX_RST_CFG 8'h19
`define FRR_IDX_MASK_LO 8'h1A
`define FRR_IDX_MASK_HI 8'h1B
`define FRR_IDX_SAVE_SEL 8'h47
`define FRR_IDX_SW_EN 8'h4D
`define FRR_IDX_RECOV 8'h4F
`define FRR_IDX_CRIT_EN 8'h60
`define FRR_IDX_SLOT12 8'h61
`define FRR_IDX_GP_CFG 8'h62
`define FRR_IDX_STATUS 8'h63

// field positions
`define FRR_RCFG_POL 2
`define FRR_RCFG_PP 3
`define FRR_RECOV_LATCH 3
`define FRR_SWEN_BIT 0

// reset values, plus the save code for nothing
`define FRR_RST_RCFG 7'h00
`define FRR_RST_RECOV 8'h00
`define FRR_RST_SAVE 2'h0
`define FRR_RST_SWEN 4'h1
`define FRR_RST_LOG 8'hF0
`define FRR_SAVE_NONE 2'h3
`define FRR_SYNC_RST 2'h1

// timing: clock rate and times in microseconds
`define FRR_CLK_MHZ 20
`define FRR_CYC(us) ((us) * `FRR_CLK_MHZ)
`define FRR_RTO_US_0 25
`define FRR_RTO_US_1 2000
`define FRR_RTO_US_2 25000
`define FRR_RTO_US_3 100000
`define FRR_RTO_US_4 200000
`define FRR_RTO_US_5 400000
`define FRR_RTO_US_6 800000
`define FRR_RTO_US_7 1600000
`define FRR_RETRY_US_0 20
`define FRR_RETRY_US_1 12500
`define FRR_RETRY_US_2 25000
`define FRR_RETRY_US_3 50000
`define FRR_RETRY_US_4 100000
`define FRR_RETRY_US_5 200000
`define FRR_RETRY_US_6 400000
`define FRR_RETRY_US_7 1600000

`endif

// ---- src/frr_fault_reset_ctrl.sv ----
`include "frr_defines.svh"
`default_nettype none
// Contract
// - a sequencing fault during power-up or power-down drops every enable
// - sequencing fault logs the failing slot unless saving is off
// - tracking fault clears failed channel log bits unless saving is off
// - recovery bit 0: shut down, restart after the retry delay
// - retry delay code picks 20us up to 1.6s
// - recovery bit 1: stay off until enable toggles or soft bit cleared
// - save code picks lines plus values, lines, values, or nothing
// - reset held through sequencing, released timeout after power-up
// - power-up done when slot 12 monitors pass, else slot delay ends
// - monitors with critical enables also drive reset
// - reset condition code picks undervoltage, warning, over, or both
// - polarity bit: 0 active low, 1 active high
// - drive bit: 1 push-pull, 0 open-drain
// - reset timeout code picks 25us up to 1600ms
// - dependency masks map monitors 1 to 12 onto reset
// - manual reset input low asserts reset when enabled
// - soft enable 0 plus enable pin high allows sequencing
module frr_fault_reset_ctrl import frr_pkg::*; #(
	parameter logic [7:0][24:0] RETRY_CYC = {
		25'(`FRR_CYC(`FRR_RETRY_US_7)),
		25'(`FRR_CYC(`FRR_RETRY_US_6)),
		25'(`FRR_CYC(`FRR_RETRY_US_5)),
		25'(`FRR_CYC(`FRR_RETRY_US_4)),
		25'(`FRR_CYC(`FRR_RETRY_US_3)),
		25'(`FRR_CYC(`FRR_RETRY_US_2)),
		25'(`FRR_CYC(`FRR_RETRY_US_1)),
		25'(`FRR_CYC(`FRR_RETRY_US_0))
	},
	parameter logic [7:0][24:0] RTO_CYC = {
		25'(`FRR_CYC(`FRR_RTO_US_7)),
		25'(`FRR_CYC(`FRR_RTO_US_6)),
		25'(`FRR_CYC(`FRR_RTO_US_5)),
		25'(`FRR_CYC(`FRR_RTO_US_4)),
		25'(`FRR_CYC(`FRR_RTO_US_3)),
		25'(`FRR_CYC(`FRR_RTO_US_2)),
		25'(`FRR_CYC(`FRR_RTO_US_1)),
		25'(`FRR_CYC(`FRR_RTO_US_0))
	}
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic enable_pin_in,
	input wire logic general_pin_four_in,
	input wire frr_mon_t voltage_monitor_input_in,
	input wire frr_seq_t seq_in,
	input wire logic [3:0] tracking_fault_in,
	output logic [11:0] supply_enable_out,
	output logic seq_run_out,
	output logic log_write_out,
	output logic log_lines_out,
	output logic log_values_out,
	output logic [7:0] failing_slot_log_out,
	output logic reset_pin_out,
	output logic reset_pin_oe_out
);
	typedef struct packed {
		frr_state_t state;
		logic [11:0] sup_en;
		logic run;
		logic pu_done;
		logic [7:0] log;
		logic log_wr;
		logic log_lines;
		logic log_values;
		logic [6:0] rcfg;
		logic [11:0] mask;
		logic [7:0] recov;
		logic [1:0] save_sel;
		logic [3:0] swen;
		logic [11:0] crit;
		logic [11:0] slot12;
		logic mr_en;
		logic [31:0] prdata;
		logic pslverr;
		logic rst_pin;
		logic rst_oe;
	} frr_ctrl_st_t;

	frr_ctrl_st_t st;
	frr_ctrl_st_t next_st;

	logic [1:0] pins;
	logic en_pin;
	logic mr_pin;
	logic [7:0] idx;
	logic aligned;
	logic hit;
	logic wr;
	logic [31:0] rd_val;
	logic en_ok;
	logic [11:0] mon_bad;
	logic [11:0] sel_cond;
	logic mon_trip;
	logic crit_trip;
	logic seq_fault;
	logic fault;
	logic latch_mode;
	logic sw_clear_wr;
	logic pu_complete;
	logic mr_active;
	logic rst_cond;
	logic rto_done;
	logic rst_act;
	logic level_hi;
	logic retry_load;
	logic retry_done;
	logic save_on;

	frr_sync u_sync (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.pin_in({enable_pin_in, general_pin_four_in}),
		.level_out(pins)
	);
	assign en_pin = pins[1];
	assign mr_pin = pins[0];

	// register bus decode
	assign idx = paddr_in[9:2];
	assign aligned = (paddr_in[1:0] == 2'h0) && (paddr_in[11:10] == 2'h0);
	always_comb begin
		hit = 1'b0;
		rd_val = 32'h00000000;
		case (idx)
			`FRR_IDX_FAULT_LOG: begin
				hit = aligned;
				rd_val = {24'h000000, st.log};
			end
			`FRR_IDX_RST_CFG: begin
				hit = aligned;
				rd_val = {25'h0000000, st.rcfg};
			end
			`FRR_IDX_MASK_LO: begin
				hit = aligned;
				rd_val = {24'h000000, st.mask[7:0]};
			end
			`FRR_IDX_MASK_HI: begin
				hit = aligned;
				rd_val = {28'h0000000, st.mask[11:8]};
			end
			`FRR_IDX_SAVE_SEL: begin
				hit = aligned;
				rd_val = {30'h00000000, st.save_sel};
			end
			`FRR_IDX_SW_EN: begin
				hit = aligned;
				rd_val = {28'h0000000, st.swen};
			end
			`FRR_IDX_RECOV: begin
				hit = aligned;
				rd_val = {24'h000000, st.recov};
			end
			`FRR_IDX_CRIT_EN: begin
				hit = aligned;
				rd_val = {20'h00000, st.crit};
			end
			`FRR_IDX_SLOT12: begin
				hit = aligned;
				rd_val = {20'h00000, st.slot12};
			end
			`FRR_IDX_GP_CFG: begin
				hit = aligned;
				rd_val = {31'h00000000, st.mr_en};
			end
			`FRR_IDX_STATUS: begin
				hit = aligned;
				rd_val = {27'h0000000, rst_act, st.pu_done, en_ok,
					st.state};
			end
			default: begin
				hit = 1'b0;
				rd_val = 32'h00000000;
			end
		endcase
	end
	assign wr = psel_in && penable_in && pwrite_in && hit;

	// soft enable and pin together gate sequencing
	assign en_ok = en_pin && !st.swen[`FRR_SWEN_BIT];
	assign sw_clear_wr = wr && (idx == `FRR_IDX_SW_EN)
		&& !pwdata_in[`FRR_SWEN_BIT];
	assign latch_mode = st.recov[`FRR_RECOV_LATCH];
	assign save_on = (st.save_sel != `FRR_SAVE_NONE);

	// critical faults count only once the rails are up
	assign crit_trip = |(st.crit & (voltage_monitor_input_in.uv
		| voltage_monitor_input_in.ov)) && st.pu_done;
	// fault seen while sequencing drops rails whatever crit enables say
	assign seq_fault = seq_in.fault && (seq_in.up || seq_in.down)
		&& (st.state == FRR_RUN);
	assign fault = (st.state == FRR_RUN) && (seq_fault || crit_trip);
	assign retry_load = fault && !latch_mode;

	frr_timer u_retry (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.load_in(retry_load),
		.count_in(RETRY_CYC[st.recov[2:0]]),
		.done_out(retry_done)
	);

	// slot 12 empty means the slot delay decides
	assign pu_complete = (st.slot12 != 12'h000)
		? ((st.slot12 & ~voltage_monitor_input_in.uv) == st.slot12)
		: seq_in.slot12_delay_done;

	// selected trip condition per monitor
	always_comb begin
		case (st.rcfg[1:0])
			2'h0: sel_cond = voltage_monitor_input_in.uv;
			2'h1: sel_cond = voltage_monitor_input_in.ew;
			2'h2: sel_cond = voltage_monitor_input_in.ov;
			default: sel_cond = voltage_monitor_input_in.uv
				| voltage_monitor_input_in.ov;
		endcase
	end
	assign mon_bad = (st.mask | st.crit) & sel_cond;
	assign mon_trip = |mon_bad;
	assign mr_active = st.mr_en && !mr_pin;

	// anything but a finished power-up holds reset
	assign rst_cond = (st.state != FRR_RUN) || !st.pu_done
		|| seq_in.down || mon_trip || mr_active;

	// timer reloads while the cause stands, so the timeout runs after it
	frr_timer u_rto (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.load_in(rst_cond),
		.count_in(RTO_CYC[st.rcfg[6:4]]),
		.done_out(rto_done)
	);
	assign rst_act = rst_cond || !rto_done;
	assign level_hi = st.rcfg[`FRR_RCFG_POL] ? rst_act : !rst_act;

	always_comb begin
		next_st = st;
		next_st.log_wr = 1'b0;

		// register writes
		if (wr) begin
			case (idx)
				`FRR_IDX_RST_CFG: next_st.rcfg = pwdata_in[6:0];
				`FRR_IDX_MASK_LO: next_st.mask[7:0] = pwdata_in[7:0];
				`FRR_IDX_MASK_HI: next_st.mask[11:8] = pwdata_in[3:0];
				`FRR_IDX_SAVE_SEL: next_st.save_sel = pwdata_in[1:0];
				`FRR_IDX_SW_EN: next_st.swen = pwdata_in[3:0];
				`FRR_IDX_RECOV: next_st.recov = pwdata_in[7:0];
				`FRR_IDX_CRIT_EN: next_st.crit = pwdata_in[11:0];
				`FRR_IDX_SLOT12: next_st.slot12 = pwdata_in[11:0];
				`FRR_IDX_GP_CFG: next_st.mr_en = pwdata_in[0];
				default: next_st.mr_en = st.mr_en;
			endcase
		end

		// read data and error latched in setup, shown in access
		if (psel_in && !penable_in) begin
			next_st.prdata = pwrite_in ? 32'h00000000 : rd_val;
			next_st.pslverr = !hit;
		end

		// recovery state machine
		case (st.state)
			FRR_IDLE: begin
				if (en_ok) begin
					next_st.state = FRR_RUN;
				end
			end
			FRR_RUN: begin
				if (fault) begin
					next_st.state = latch_mode ? FRR_LATCH
						: FRR_RETRY;
				end else if (!en_ok) begin
					next_st.state = FRR_IDLE;
				end
			end
			FRR_RETRY: begin
				if (!en_ok) begin
					next_st.state = FRR_IDLE;
				end else if (retry_done) begin
					next_st.state = FRR_RUN;
				end
			end
			FRR_LATCH: begin
				// a soft write of 0 restarts even if already 0
				if (!en_pin || sw_clear_wr) begin
					next_st.state = FRR_IDLE;
				end
			end
			default: next_st.state = FRR_IDLE;
		endcase

		// rails off while waiting out a retry or latched
		if (next_st.state == FRR_RETRY || next_st.state == FRR_LATCH) begin
			next_st.sup_en = 12'h000;
		end else begin
			next_st.sup_en = seq_in.enable;
		end
		next_st.run = (next_st.state == FRR_RUN) && en_ok;

		// power-up completion flag
		if (next_st.state != FRR_RUN || seq_in.down) begin
			next_st.pu_done = 1'b0;
		end else if (seq_in.up && pu_complete) begin
			next_st.pu_done = 1'b1;
		end

		// fault log location zero
		if (save_on && seq_fault) begin
			next_st.log[3:0] = seq_in.slot;
			next_st.log_wr = 1'b1;
		end
		if (save_on && (tracking_fault_in != 4'h0)) begin
			next_st.log[7:4] = st.log[7:4] & ~tracking_fault_in;
			next_st.log_wr = 1'b1;
		end
		// critical faults store too, as the save code asks
		if (save_on && fault) begin
			next_st.log_wr = 1'b1;
		end
		if (next_st.log_wr) begin
			next_st.log_lines = (st.save_sel == 2'h0)
				|| (st.save_sel == 2'h1);
			next_st.log_values = (st.save_sel == 2'h0)
				|| (st.save_sel == 2'h2);
		end

		// open-drain only ever pulls low
		if (st.rcfg[`FRR_RCFG_PP]) begin
			next_st.rst_pin = level_hi;
			next_st.rst_oe = 1'b1;
		end else begin
			next_st.rst_pin = 1'b0;
			next_st.rst_oe = !level_hi;
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st <= '0;
			st.state <= FRR_IDLE;
			st.log <= `FRR_RST_LOG;
			st.rcfg <= `FRR_RST_RCFG;
			st.recov <= `FRR_RST_RECOV;
			st.save_sel <= `FRR_RST_SAVE;
			st.swen <= `FRR_RST_SWEN;
			st.rst_pin <= 1'b0;
			st.rst_oe <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign pready_out = psel_in && penable_in;
	assign prdata_out = st.prdata;
	assign pslverr_out = st.pslverr && psel_in && penable_in;
	assign supply_enable_out = st.sup_en;
	assign seq_run_out = st.run;
	assign log_write_out = st.log_wr;
	assign log_lines_out = st.log_lines;
	assign log_values_out = st.log_values;
	assign failing_slot_log_out = st.log;
	assign reset_pin_out = st.rst_pin;
	assign reset_pin_oe_out = st.rst_oe;
endmodule
`default_nettype wire

// ---- src/frr_pkg.sv ----
`default_nettype none
package frr_pkg;
	typedef enum logic [1:0] {
		FRR_IDLE,
		FRR_RUN,
		FRR_RETRY,
		FRR_LATCH
	} frr_state_t;

	typedef struct packed {
		logic [11:0] uv;
		logic [11:0] ov;
		logic [11:0] ew;
	} frr_mon_t;

	typedef struct packed {
		logic up;
		logic down;
		logic fault;
		logic [3:0] slot;
		logic slot12_delay_done;
		logic [11:0] enable;
	} frr_seq_t;

	typedef struct packed {
		logic [24:0] cnt;
	} frr_timer_st_t;

	typedef struct packed {
		logic [1:0] ff1;
		logic [1:0] ff2;
		logic [1:0] ff3;
		logic [1:0] stable;
	} frr_sync_st_t;
endpackage
`default_nettype wire

// ---- src/frr_sync.sv ----
`include "frr_defines.svh"
`default_nettype none
module frr_sync import frr_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic [1:0] pin_in,
	output logic [1:0] level_out
);
	frr_sync_st_t st;
	frr_sync_st_t next_st;

	always_comb begin
		next_st = st;
		next_st.ff1 = pin_in;
		next_st.ff2 = st.ff1;
		next_st.ff3 = st.ff2;
		// accept a change only once stages two and three agree
		for (int i = 0; i < 2; i++) begin
			if (st.ff2[i] == st.ff3[i]) begin
				next_st.stable[i] = st.ff3[i];
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st <= {4{`FRR_SYNC_RST}};
		end else begin
			st <= next_st;
		end
	end

	assign level_out = st.stable;
endmodule
`default_nettype wire

// ---- src/frr_timer.sv ----
`default_nettype none
module frr_timer import frr_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic load_in,
	input wire logic [24:0] count_in,
	output logic done_out
);
	frr_timer_st_t st;
	frr_timer_st_t next_st;

	always_comb begin
		next_st = st;
		if (load_in) begin
			next_st.cnt = count_in;
		end else if (st.cnt != 25'h0000000) begin
			next_st.cnt = st.cnt - 25'h0000001;
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign done_out = (st.cnt == 25'h0000000);
endmodule
`default_nettype wire

// ---- verif/frr_fault_reset_ctrl_chk.sv ----
`default_nettype none
module frr_fault_reset_ctrl_chk import frr_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic enable_pin_in,
	input wire frr_seq_t seq_in,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [11:0] supply_enable_out,
	input wire logic seq_run_out,
	input wire logic log_write_out,
	input wire logic log_lines_out,
	input wire logic log_values_out,
	input wire logic [7:0] failing_slot_log_out,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe_out
);
	default clocking @(posedge clk_sys_in);
	endclocking
	default disable iff (!resetn_in);
	sequence seq_fault_s;
		seq_in.fault && (seq_in.up || seq_in.down) && seq_run_out;
	endsequence
	acc_ready_a: assert property (psel_in && penable_in |-> pready_out)
		else $error("no ready in access");
	err_phase_a: assert property (pslverr_out |-> psel_in && penable_in)
		else $error("error outside access");
	fault_off_a: assert property (
		seq_fault_s |=> supply_enable_out == 12'h000)
		else $error("rails on after fault");
	slot_log_a: assert property (
		seq_fault_s ##1 log_write_out |->
		failing_slot_log_out[3:0] == $past(seq_in.slot))
		else $error("wrong slot logged");
	log_pulse_a: assert property (
		log_write_out |=> !log_write_out)
		else $error("log pulse too long");
	log_kind_a: assert property (
		log_write_out |-> log_lines_out || log_values_out)
		else $error("log with nothing to store");
	rail_gate_a: assert property (
		!seq_run_out |=> supply_enable_out == 12'h000)
		else $error("rails on while stopped");
	rst_hold_a: assert property (
		seq_in.up && $past(seq_in.up) |->
		$stable({reset_pin_out, reset_pin_oe_out}))
		else $error("reset moved during power-up");
	en_low_a: assert property (
		!enable_pin_in [*6] |-> !seq_run_out)
		else $error("running with enable low");
endmodule
bind frr_fault_reset_ctrl frr_fault_reset_ctrl_chk i_chk (
	.clk_sys_in, .resetn_in, .psel_in, .penable_in, .enable_pin_in,
	.seq_in, .pready_out, .pslverr_out, .supply_enable_out, .seq_run_out,
	.log_write_out, .log_lines_out, .log_values_out,
	.failing_slot_log_out, .reset_pin_out, .reset_pin_oe_out
);
`default_nettype wire

// ---- verif/frr_rail_model.sv ----
`default_nettype none
// rails and sequencer seen from the block; RAMP sets how many one-cycle slots power-up lasts
module frr_rail_model import frr_pkg::*; #(
	parameter int RAMP = 6
) (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic seq_run_in,
	input wire logic [11:0] rail_en_in,
	input wire logic fault_in,
	input wire frr_mon_t force_in,
	output frr_seq_t seq_out,
	output frr_mon_t mon_out
);
	logic [3:0] step;
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in)
			step <= 4'h0;
		else if (!seq_run_in)
			step <= 4'h0;
		else if (step != 4'(RAMP))
			step <= step + 4'h1;
	end
	always_comb begin
		seq_out = '0;
		seq_out.up = seq_run_in && step != 4'(RAMP);
		seq_out.fault = fault_in;
		seq_out.slot = step;
		// overlaps the last power-up cycle so completion is seen
		seq_out.slot12_delay_done = step >= 4'(RAMP - 1);
		seq_out.enable = seq_run_in ? 12'hFFF : 12'h000;
		mon_out = force_in;
		// a rail that is switched off reads below its threshold
		mon_out.uv = force_in.uv | ~rail_en_in;
	end
endmodule
`default_nettype wire

// ---- verif/test_fault_recovery_reset_ctrl.sv ----
`default_nettype none
module test_fault_recovery_reset_ctrl import frr_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	// short counts so every delay code runs in a few dozen cycles
	localparam logic [7:0][24:0] RTO = {25'h1A, 25'h18, 25'h16, 25'h14,
		25'h12, 25'h10, 25'h0E, 25'h0C};
	localparam logic [7:0][24:0] RTY = {25'h24, 25'h20, 25'h1C, 25'h18,
		25'h14, 25'h10, 25'h0C, 25'h08};
	logic clk_sys_in = 1'b0;
	logic resetn_in = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic en = 1'b0;
	logic mr_n = 1'b1;
	logic flt = 1'b0;
	logic [3:0] trk = 4'h0;
	frr_mon_t frc = '0;
	logic [7:0] cfg = 8'h00;
	logic [7:0] ri [5] = '{8'h19, 8'h4F, 8'h47, 8'h4D, 8'h00};
	logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'hF0};
	logic [31:0] prdata, d;
	logic pready, pslverr, e, run, lw, ll, lv, rp, roe;
	logic [11:0] sen;
	logic [7:0] slog;
	logic [1:0] last_lv;
	frr_mon_t mon;
	frr_seq_t seq;
	int mismatches = 0;
	int n_tests = 0;
	int n_log = 0;
	always #25 clk_sys_in = ~clk_sys_in;
	frr_fault_reset_ctrl #(.RETRY_CYC(RTY), .RTO_CYC(RTO))
		i_frr_fault_reset_ctrl (
		.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .enable_pin_in(en),
		.general_pin_four_in(mr_n), .voltage_monitor_input_in(mon),
		.seq_in(seq), .tracking_fault_in(trk), .supply_enable_out(sen),
		.seq_run_out(run), .log_write_out(lw), .log_lines_out(ll),
		.log_values_out(lv), .failing_slot_log_out(slog),
		.reset_pin_out(rp), .reset_pin_oe_out(roe));
	frr_rail_model i_frr_rail_model (
		.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .seq_run_in(run),
		.rail_en_in(sen), .fault_in(flt), .force_in(frc), .seq_out(seq),
		.mon_out(mon));
	always @(posedge clk_sys_in) begin
		if (lw === 1'b1) begin
			n_log++;
			last_lv <= {ll, lv};
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, x);
		n_tests++;
		if (s !== x) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	task automatic bus(input logic w, input logic [7:0] i,
		input logic [31:0] wd);
		@(posedge clk_sys_in);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'h0, i, 2'h0};
		pwdata <= wd;
		@(posedge clk_sys_in);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys_in);
		end while (pready !== 1'b1);
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] v);
		bus(1'b1, i, {24'h0, v});
		if (i == 8'h19)
			cfg = v;
	endtask
	task automatic rd(input string nm, input logic [7:0] i,
		input logic [31:0] x);
		bus(1'b0, i, 32'h0);
		chk(nm, d, x);
	endtask
	// asserted level; held() is never called with open-drain active-high set
	function automatic logic held();
		return rp === cfg[2] && roe === 1'b1;
	endfunction
	task automatic till(input logic v, output int k);
		k = 0;
		while (run !== v && k < 400) begin
			@(posedge clk_sys_in);
			k++;
		end
		if (k >= 400)
			mismatches++;
	endtask
	task automatic pu(input logic [24:0] t);
		int k;
		k = 0;
		while (seq.slot12_delay_done !== 1'b1 && k < 400) begin
			@(posedge clk_sys_in);
			k++;
		end
		if (k >= 400)
			mismatches++;
		chk("held_pu", held(), 1'b1);
		k = 0;
		while (held() && k < 400) begin
			@(posedge clk_sys_in);
			k++;
		end
		chk("rto", k >= t && k <= t + 4, 1'b1);
		chk("rails", sen, 12'hFFF);
	endtask
	function automatic frr_mon_t mk(input int c);
		mk = '0;
		if (c == 0)
			mk.uv[0] = 1'b1;
		if (c == 1)
			mk.ew[0] = 1'b1;
		if (c == 2)
			mk.ov[0] = 1'b1;
		if (c == 3)
			mk.ov[11] = 1'b1;
	endfunction
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		int k, kr;
		logic [3:0] x;
		cyc(4);
		resetn_in <= 1'b1;
		chk("rst_init", held(), 1'b1);
		for (int j = 0; j < 5; j++)
			rd("reg_rst", ri[j], {24'h0, rv[j]});
		rd("unmapped", 8'h30, 32'h0);
		chk("slverr", e, 1'b1);
		wr(8'h00, 8'h00);
		rd("log_ro", 8'h00, 32'hF0);
		wr(8'h19, 8'hFF);
		rd("cfg_rw", 8'h19, 32'h7F);
		en <= 1'b1;
		cyc(8);
		chk("soft_off", run, 1'b0);
		wr(8'h19, 8'h1C);
		wr(8'h1A, 8'h01);
		wr(8'h1B, 8'h08);
		wr(8'h4D, 8'h00);
		till(1'b1, kr);
		pu(RTO[1]);
		chk("pp_high", {rp, roe}, 2'b01);
		wr(8'h19, 8'h18);
		cyc(2);
		chk("pp_low", {rp, roe}, 2'b11);
		wr(8'h19, 8'h14);
		cyc(2);
		chk("od_high", {rp, roe}, 2'b01);
		wr(8'h19, 8'h10);
		cyc(2);
		chk("od_off", roe, 1'b0);
		for (int c = 0; c < 4; c++) begin
			wr(8'h19, 8'h10 | 8'(c));
			frc <= mk(c);
			cyc(4);
			chk("trip", held(), 1'b1);
			frc <= '0;
			cyc(24);
			chk("untrip", held(), 1'b0);
		end
		frc <= mk(1);
		cyc(4);
		chk("no_trip", held(), 1'b0);
		frc <= '0;
		wr(8'h62, 8'h01);
		mr_n <= 1'b0;
		cyc(8);
		chk("mr", held(), 1'b1);
		mr_n <= 1'b1;
		cyc(28);
		chk("mr_off", held(), 1'b0);
		wr(8'h60, 8'h01);
		for (int s = 0; s < 4; s++) begin
			wr(8'h47, 8'(s));
			wr(8'h4F, 8'(s));
			k = n_log;
			frc.uv[0] <= 1'b1;
			@(posedge clk_sys_in);
			frc.uv[0] <= 1'b0;
			cyc(2);
			chk("rail_off", sen, 12'h000);
			chk("retry_rst", held(), 1'b1);
			till(1'b1, kr);
			chk("retry_t", kr + 2 >= RTY[s] && kr + 2 <= RTY[s] + 5,
				1'b1);
			chk("logs", n_log - k, s != 3);
			if (s != 3)
				chk("kind", last_lv, {s < 2, s != 1});
			pu(RTO[1]);
		end
		wr(8'h4F, 8'h08);
		wr(8'h47, 8'h00);
		wr(8'h4D, 8'h01);
		till(1'b0, kr);
		wr(8'h4D, 8'h00);
		till(1'b1, kr);
		cyc(2);
		flt <= 1'b1;
		@(posedge clk_sys_in);
		x = seq.slot;
		flt <= 1'b0;
		cyc(2);
		chk("seq_off", sen, 12'h000);
		chk("slot", slog[3:0], x);
		bus(1'b0, 8'h63, 32'h0);
		chk("latched", d[1:0], 2'h3);
		cyc(40);
		chk("stay_off", run, 1'b0);
		wr(8'h4D, 8'h00);
		till(1'b1, kr);
		chk("restart", run, 1'b1);
		pu(RTO[1]);
		trk <= 4'h2;
		@(posedge clk_sys_in);
		trk <= 4'h0;
		cyc(3);
		chk("track", slog[7:4], 4'hD);
		end_of_test();
	end
	initial begin
		#2000000;
		mismatches++;
		end_of_test();
	end
endmodule
`default_nettype wire
